// [cpu_exec_pkg.sv]
// constants, opcodes and register map of the branch, skip and load execution unit
// assumes a 32-bit classic wishbone register bus and a byte-wide data space
package cpu_exec_pkg;

  // ***************
  // register offsets
  // ***************
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_PC = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_PTR = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_STACK = 8'h18;
  localparam logic [7:0] OFS_GPR_BASE = 8'h80;

  // ***************
  // instruction word, status and pointer register fields
  // ***************
  localparam int INSTR_OP_LSB = 0;
  localparam int INSTR_RD_LSB = 5;
  localparam int INSTR_RR_LSB = 10;
  localparam int INSTR_BIT_LSB = 15;
  localparam int INSTR_IMM_LSB = 18;
  localparam int INSTR_LONG_BIT = 26;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_LEN_LSB = 8;
  localparam int PTR_Y_LSB = 16;

  // ***************
  // status flag positions
  // ***************
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ***************
  // reset values
  // ***************
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h00FF;
  localparam logic [7:0] GPR_RST = 8'h00;

  // ***************
  // cycle counts
  // ***************
  localparam logic [3:0] LEN_REG = 4'h1;
  localparam logic [3:0] LEN_MEM = 4'h2;
  localparam logic [3:0] LEN_POP = 4'h4;

  // ***************
  // opcodes, encoded in listed order from 0
  // ***************
  typedef enum logic [4:0] {
    op_compare, op_compare_with_carry, op_compare_immediate, op_compare_skip_equal,
    op_skip_reg_bit_clear, op_skip_reg_bit_set, op_skip_io_bit_clear, op_skip_io_bit_set,
    op_branch_flag_set, op_branch_flag_clear, op_branch_zero_set, op_branch_zero_clear,
    op_branch_carry_clear, op_branch_same_higher, op_branch_signed_ge, op_branch_signed_lt,
    op_branch_halfcarry_set, op_branch_halfcarry_clear, op_branch_transfer_set,
    op_branch_transfer_clear, op_branch_overflow_set, op_branch_overflow_clear,
    op_branch_irq_enabled, op_branch_irq_disabled, op_load_x, op_load_x_inc, op_load_x_dec,
    op_load_y, op_load_y_inc, op_load_direct, op_subroutine_return, op_interrupt_return
  } op_type;

endpackage

// [cond_if.sv]
// signals between the execution core and its condition and compare unit
// assumes both ends sit on the same clock; the unit is purely combinational
`timescale 1ns/1ps
interface cond_if;
  import cpu_exec_pkg::*;
  op_type op;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] flags;
  logic [2:0] bit_sel;
  logic [7:0] io_byte;
  logic [7:0] flags_out;
  logic hit;
  modport unit (input op, a, b, flags, bit_sel, io_byte, output flags_out, hit);
  modport core (output op, a, b, flags, bit_sel, io_byte, input flags_out, hit);
endinterface

// [condition_unit.sv]
// compare flags and skip or branch condition of the current instruction
// assumes operands stay stable for the whole cycle they are used in
`timescale 1ns/1ps
module condition_unit
  import cpu_exec_pkg::*;
(
  // core side
  cond_if.unit c
);

  logic [8:0] diff;
  logic [7:0] r;
  logic borrow_in;

  // ***************
  // compare arithmetic
  // ***************
  always_comb begin
    borrow_in = (c.op == op_compare_with_carry) ? c.flags[FLAG_C] : 1'b0;
    diff = {1'b0, c.a} - {1'b0, c.b} - {8'h00, borrow_in};
    r = diff[7:0];
    c.flags_out = c.flags;
    c.flags_out[FLAG_H] = (~c.a[3] & c.b[3]) | (c.b[3] & r[3]) | (r[3] & ~c.a[3]);
    c.flags_out[FLAG_C] = (~c.a[7] & c.b[7]) | (c.b[7] & r[7]) | (r[7] & ~c.a[7]);
    c.flags_out[FLAG_V] = (c.a[7] & ~c.b[7] & ~r[7]) | (~c.a[7] & c.b[7] & r[7]);
    c.flags_out[FLAG_N] = r[7];
    c.flags_out[FLAG_S] = r[7] ^ c.flags_out[FLAG_V];
    if (c.op == op_compare_with_carry) begin
      c.flags_out[FLAG_Z] = (r == 8'h00) & c.flags[FLAG_Z];
    end else begin
      c.flags_out[FLAG_Z] = (r == 8'h00);
    end
  end

  // ***************
  // skip and branch condition
  // ***************
  always_comb begin
    unique case (c.op)
      op_compare_skip_equal: c.hit = (c.a == c.b);
      op_skip_reg_bit_clear: c.hit = ~c.a[c.bit_sel];
      op_skip_reg_bit_set: c.hit = c.a[c.bit_sel];
      op_skip_io_bit_clear: c.hit = ~c.io_byte[c.bit_sel];
      op_skip_io_bit_set: c.hit = c.io_byte[c.bit_sel];
      op_branch_flag_set: c.hit = c.flags[c.bit_sel];
      op_branch_flag_clear: c.hit = ~c.flags[c.bit_sel];
      op_branch_zero_set: c.hit = c.flags[FLAG_Z];
      op_branch_zero_clear: c.hit = ~c.flags[FLAG_Z];
      op_branch_carry_clear, op_branch_same_higher: c.hit = ~c.flags[FLAG_C];
      op_branch_signed_ge: c.hit = ~(c.flags[FLAG_N] ^ c.flags[FLAG_V]);
      op_branch_signed_lt: c.hit = c.flags[FLAG_N] ^ c.flags[FLAG_V];
      op_branch_halfcarry_set: c.hit = c.flags[FLAG_H];
      op_branch_halfcarry_clear: c.hit = ~c.flags[FLAG_H];
      op_branch_transfer_set: c.hit = c.flags[FLAG_T];
      op_branch_transfer_clear: c.hit = ~c.flags[FLAG_T];
      op_branch_overflow_set: c.hit = c.flags[FLAG_V];
      op_branch_overflow_clear: c.hit = ~c.flags[FLAG_V];
      op_branch_irq_enabled: c.hit = c.flags[FLAG_I];
      op_branch_irq_disabled: c.hit = ~c.flags[FLAG_I];
      op_compare, op_compare_with_carry, op_compare_immediate, op_load_x, op_load_x_inc,
      op_load_x_dec, op_load_y, op_load_y_inc, op_load_direct, op_subroutine_return,
      op_interrupt_return: c.hit = 1'b0;
    endcase
  end

endmodule

// [cpu_branch_skip_load_unit.sv]
// execution unit for compare, skip, flag branch, data load and return instructions
// assumes a classic wishbone master and a data space that answers a read in the same cycle
//
// Summary of operation
// - compare-skip-equal skips the next one- or two-word instruction when both registers match, in 1, 2 or 3 cycles.
// - register bit skips test one bit of a general register and skip on 0 or on 1, in 1, 2 or 3 cycles.
// - I/O bit skips read an I/O location and skip on a clear or set bit, in 2, 3 or 4 cycles.
// - generic flag branches go to PC + k + 1 when the indexed status flag is set or clear, in 1 or 2 cycles.
// - carry-clear and same-or-higher branches go to PC + k + 1 when carry is 0, in 1 or 2 cycles.
// - signed branches use N xor V, greater-or-equal on 0 and less-than on 1, in 1 or 2 cycles.
// - half-carry branches go to PC + k + 1 on H set or clear, in 1 or 2 cycles.
// - transfer-bit branches go to PC + k + 1 on T set or clear, in 1 or 2 cycles.
// - overflow branches go to PC + k + 1 on V set or clear, in 1 or 2 cycles.
// - interrupt-state branches go to PC + k + 1 on I set or clear, in 1 or 2 cycles.
// - direct load copies the byte at a 16-bit address into the destination in 2 cycles, flags kept.
// - post-increment loads via X or Y read at the pointer then add one to it, flags kept.
// - pre-decrement load via X subtracts one first and reads at the new address in 2 cycles.
//
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module cpu_branch_skip_load_unit
  import cpu_exec_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // data space
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_io,
  input wire logic [7:0] mem_rdata,
  // execution state
  output logic busy
);

  typedef enum logic {st_idle, st_run} state_type;

  state_type state_q;
  logic [7:0] gpr_q [32];
  logic [15:0] pc_q;
  logic [7:0] flags_q;
  logic [15:0] x_q;
  logic [15:0] y_q;
  logic [15:0] sp_q;
  logic [15:0] addr16_q;
  op_type op_q;
  logic [4:0] rd_q;
  logic [4:0] rr_q;
  logic [2:0] bit_q;
  logic [7:0] imm_q;
  logic long_q;
  logic [3:0] step_q;
  logic [3:0] len_q;
  logic [3:0] last_len_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic [15:0] mem_addr_q;
  logic mem_rd_q;
  logic mem_io_q;

  logic bus_req;
  logic bus_wr;
  logic start;
  logic [31:0] rd_word;
  logic cls_cmp;
  logic cls_skip;
  logic cls_io;
  logic cls_branch;
  logic cls_load;
  logic cls_pop;
  logic decide;
  logic [3:0] extra;
  logic [3:0] base_len;
  logic [3:0] cur_len;
  logic finish;
  logic [15:0] offset;
  logic [15:0] pc_next;
  logic [15:0] load_addr;

  cond_if cif ();

  condition_unit u_cond (
    .c(cif)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;
  assign mem_addr = mem_addr_q;
  assign mem_rd = mem_rd_q;
  assign mem_io = mem_io_q;
  assign busy = (state_q == st_run);

  // ***************
  // bus decode
  // ***************
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_wr = bus_req & wb_we_i & ack_q & (state_q == st_idle);
  assign start = bus_wr & (wb_adr_i == OFS_INSTR);

  always_comb begin
    rd_word = 32'h0000_0000;
    if (wb_adr_i >= OFS_GPR_BASE) begin
      rd_word = {24'h000000, gpr_q[wb_adr_i[6:2]]};
    end else begin
      unique case (wb_adr_i)
        OFS_INSTR: begin
          rd_word[INSTR_OP_LSB +: 5] = op_q;
          rd_word[INSTR_RD_LSB +: 5] = rd_q;
          rd_word[INSTR_RR_LSB +: 5] = rr_q;
          rd_word[INSTR_BIT_LSB +: 3] = bit_q;
          rd_word[INSTR_IMM_LSB +: 8] = imm_q;
          rd_word[INSTR_LONG_BIT] = long_q;
        end
        OFS_ADDR: rd_word = {16'h0000, addr16_q};
        OFS_PC: rd_word = {16'h0000, pc_q};
        OFS_FLAGS: rd_word = {24'h000000, flags_q};
        OFS_PTR: rd_word = {y_q, x_q};
        OFS_STATUS: begin
          rd_word[STATUS_BUSY_BIT] = (state_q == st_run);
          rd_word[STATUS_LEN_LSB +: 4] = last_len_q;
        end
        OFS_STACK: rd_word = {16'h0000, sp_q};
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  // one wait state, ack for every address
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req & ~ack_q;
      if (bus_req & ~ack_q) begin
        dat_q <= rd_word;
      end
    end
  end

  // ***************
  // instruction classes
  // ***************
  always_comb begin
    cls_cmp = (op_q == op_compare) | (op_q == op_compare_with_carry) |
              (op_q == op_compare_immediate);
    cls_skip = (op_q == op_compare_skip_equal) | (op_q == op_skip_reg_bit_clear) |
               (op_q == op_skip_reg_bit_set);
    cls_io = (op_q == op_skip_io_bit_clear) | (op_q == op_skip_io_bit_set);
    cls_load = (op_q == op_load_x) | (op_q == op_load_x_inc) | (op_q == op_load_x_dec) |
               (op_q == op_load_y) | (op_q == op_load_y_inc) | (op_q == op_load_direct);
    cls_pop = (op_q == op_subroutine_return) | (op_q == op_interrupt_return);
    cls_branch = ~(cls_cmp | cls_skip | cls_io | cls_load | cls_pop);
  end

  assign cif.op = op_q;
  assign cif.a = gpr_q[rd_q];
  assign cif.b = (op_q == op_compare_immediate) ? imm_q : gpr_q[rr_q];
  assign cif.flags = flags_q;
  assign cif.bit_sel = bit_q;
  assign cif.io_byte = mem_rdata;

  // ***************
  // cycle accounting and next program counter
  // ***************
  always_comb begin
    decide = (cls_io && step_q == 4'h1) || ((cls_skip || cls_branch) && step_q == 4'h0);
    extra = 4'h0;
    if (cif.hit && (cls_skip || cls_io)) begin
      extra = long_q ? 4'h2 : 4'h1;
    end else if (cif.hit && cls_branch) begin
      extra = 4'h1;
    end
    if (cls_pop) begin
      base_len = LEN_POP;
    end else if (cls_io || (cls_load && op_q != op_load_x && op_q != op_load_y)) begin
      base_len = LEN_MEM;
    end else if (cls_load) begin
      base_len = LEN_MEM;
    end else begin
      base_len = LEN_REG;
    end
    if (step_q == 4'h0) begin
      cur_len = base_len + (decide ? extra : 4'h0);
    end else begin
      cur_len = len_q + (decide ? extra : 4'h0);
    end
    finish = (step_q == cur_len - 4'h1);
    offset = {{9{imm_q[6]}}, imm_q[6:0]};
    if (cls_branch && cif.hit) begin
      pc_next = pc_q + offset + 16'h0001;
    end else if (cls_skip || cls_io) begin
      pc_next = pc_q + 16'h0001 + {12'h000, extra};
    end else if (op_q == op_load_direct) begin
      pc_next = pc_q + 16'h0002;
    end else begin
      pc_next = pc_q + 16'h0001;
    end
    unique case (op_q)
      op_load_x, op_load_x_inc: load_addr = x_q;
      op_load_x_dec: load_addr = x_q - 16'h0001;
      op_load_y, op_load_y_inc: load_addr = y_q;
      default: load_addr = addr16_q;
    endcase
  end

  // ***************
  // sequencer
  // ***************
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= st_idle;
      step_q <= 4'h0;
      len_q <= LEN_REG;
      last_len_q <= 4'h0;
    end else if (state_q == st_idle) begin
      step_q <= 4'h0;
      if (start) begin
        state_q <= st_run;
      end
    end else begin
      len_q <= cur_len;
      step_q <= step_q + 4'h1;
      if (finish) begin
        state_q <= st_idle;
        last_len_q <= cur_len;
      end
    end
  end

  // ***************
  // instruction latch
  // ***************
  always_ff @(posedge clk) begin
    if (reset) begin
      op_q <= op_compare;
      rd_q <= 5'h00;
      rr_q <= 5'h00;
      bit_q <= 3'h0;
      imm_q <= 8'h00;
      long_q <= 1'b0;
      addr16_q <= 16'h0000;
    end else if (start) begin
      op_q <= op_type'(wb_dat_i[INSTR_OP_LSB +: 5]);
      rd_q <= wb_dat_i[INSTR_RD_LSB +: 5];
      rr_q <= wb_dat_i[INSTR_RR_LSB +: 5];
      bit_q <= wb_dat_i[INSTR_BIT_LSB +: 3];
      imm_q <= wb_dat_i[INSTR_IMM_LSB +: 8];
      long_q <= wb_dat_i[INSTR_LONG_BIT];
    end else if (bus_wr && wb_adr_i == OFS_ADDR) begin
      addr16_q <= 16'(merge({16'h0000, addr16_q}, wb_dat_i, wb_sel_i));
    end
  end

  // ***************
  // data space reads
  // ***************
  always_ff @(posedge clk) begin
    if (reset) begin
      mem_rd_q <= 1'b0;
      mem_io_q <= 1'b0;
      mem_addr_q <= 16'h0000;
    end else begin
      mem_rd_q <= 1'b0;
      mem_io_q <= 1'b0;
      if (state_q == st_run && step_q == 4'h0) begin
        if (cls_io) begin
          mem_rd_q <= 1'b1;
          mem_io_q <= 1'b1;
          mem_addr_q <= {10'h000, addr16_q[5:0]};
        end else if (cls_load) begin
          mem_rd_q <= 1'b1;
          mem_addr_q <= load_addr;
        end else if (cls_pop) begin
          mem_rd_q <= 1'b1;
          mem_addr_q <= sp_q + 16'h0001;
        end
      end else if (state_q == st_run && step_q == 4'h1 && cls_pop) begin
        mem_rd_q <= 1'b1;
        mem_addr_q <= sp_q + 16'h0002;
      end
    end
  end

  // ***************
  // program counter, stack pointer and flags
  // ***************
  always_ff @(posedge clk) begin
    if (reset) begin
      pc_q <= PC_RST;
      sp_q <= SP_RST;
      flags_q <= FLAGS_RST;
    end else if (state_q == st_run) begin
      if (decide || (step_q == 4'h0 && (cls_cmp || cls_load))) begin
        pc_q <= pc_next;
      end
      if (step_q == 4'h0 && cls_cmp) begin
        flags_q <= cif.flags_out;
      end
      if (cls_pop && step_q == 4'h1) begin
        pc_q[15:8] <= mem_rdata;
      end
      if (cls_pop && step_q == 4'h2) begin
        pc_q[7:0] <= mem_rdata;
        sp_q <= sp_q + 16'h0002;
        if (op_q == op_interrupt_return) begin
          flags_q[FLAG_I] <= 1'b1;
        end
      end
    end else if (bus_wr) begin
      if (wb_adr_i == OFS_PC) begin
        pc_q <= 16'(merge({16'h0000, pc_q}, wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i == OFS_STACK) begin
        sp_q <= 16'(merge({16'h0000, sp_q}, wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i == OFS_FLAGS && wb_sel_i[0]) begin
        flags_q <= wb_dat_i[7:0];
      end
    end
  end

  // ***************
  // pointers
  // ***************
  always_ff @(posedge clk) begin
    if (reset) begin
      x_q <= PTR_RST;
      y_q <= PTR_RST;
    end else if (state_q == st_run && step_q == 4'h0) begin
      if (op_q == op_load_x_dec) begin
        x_q <= x_q - 16'h0001;
      end
    end else if (state_q == st_run && step_q == 4'h1) begin
      if (op_q == op_load_x_inc) begin
        x_q <= x_q + 16'h0001;
      end
      if (op_q == op_load_y_inc) begin
        y_q <= y_q + 16'h0001;
      end
    end else if (bus_wr && wb_adr_i == OFS_PTR) begin
      x_q <= 16'(merge({y_q, x_q}, wb_dat_i, wb_sel_i));
      y_q <= 16'(merge({y_q, x_q}, wb_dat_i, wb_sel_i) >> PTR_Y_LSB);
    end
  end

  // ***************
  // general registers
  // ***************
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 32; i++) begin
        gpr_q[i] <= GPR_RST;
      end
    end else if (state_q == st_run && step_q == 4'h1 && cls_load) begin
      gpr_q[rd_q] <= mem_rdata;
    end else if (bus_wr && wb_adr_i >= OFS_GPR_BASE && wb_sel_i[0]) begin
      gpr_q[wb_adr_i[6:2]] <= wb_dat_i[7:0];
    end
  end

endmodule

// [data_space_model.sv]
// data space and i/o model beside the execution unit
// assumes registered read strobe and address, answered in the same cycle
`timescale 1ns/1ps
module data_space_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // unit side
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_io,
  output logic [7:0] mem_rdata
);
  logic [7:0] idle_q;
  // idle pattern flips every cycle so stale bytes never look valid
  always_ff @(posedge clk) begin
    if (reset) begin
      idle_q <= 8'hA5;
    end else begin
      idle_q <= ~mem_rdata;
    end
  end
  // contents are a fixed function of address and space
  assign mem_rdata = mem_rd ? (mem_addr[7:0] ^ (mem_io ? 8'h3C : 8'h5A)) : idle_q;
endmodule

// [cpu_branch_skip_load_unit_checker.sv]
// port checker of the execution unit
// assumes one clock and the synchronous active high reset
`timescale 1ns/1ps
module cpu_branch_skip_load_unit_checker
  import cpu_exec_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // data space
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_io,
  input wire logic [7:0] mem_rdata,
  // execution state
  input wire logic busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic is_load;
  logic is_branch;
  assign is_load = wb_dat_i[4:0] >= op_load_x && wb_dat_i[4:0] <= op_load_direct;
  assign is_branch = wb_dat_i[4:0] >= op_branch_flag_set && wb_dat_i[4:0] <= op_branch_irq_disabled;
  chk_ack_latency: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack late");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  chk_busy_start: assert property ($rose(busy) |-> $past(wb_ack_o) && $past(wb_we_i) &&
    $past(wb_adr_i) == OFS_INSTR)
    else $error("busy without instruction");
  chk_busy_bound: assert property ($rose(busy) |-> ##[1:4] !busy)
    else $error("busy too long");
  chk_read_busy: assert property (mem_rd |-> busy)
    else $error("read while idle");
  chk_read_burst: assert property (mem_rd [*2] |=> !mem_rd)
    else $error("read burst too long");
  chk_io_space: assert property (mem_io |-> mem_rd && mem_addr[15:6] == 10'h000)
    else $error("bad i/o read");
  chk_load_reads: assert property (($rose(busy) && $past(is_load)) |-> ##[0:2] mem_rd)
    else $error("load without read");
  chk_branch_quiet: assert property (($rose(busy) && $past(is_branch)) |-> !mem_rd [*2])
    else $error("branch reads memory");
endmodule
bind cpu_branch_skip_load_unit cpu_branch_skip_load_unit_checker chk_u (.clk(clk), .reset(reset),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_io(mem_io), .mem_rdata(mem_rdata), .busy(busy));

// [cpu_branch_skip_load_unit_tb.sv]
// self-checking bench of the execution unit over wishbone
// assumes the data space model and the bound checker
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module cpu_branch_skip_load_unit_tb import cpu_exec_pkg::*;;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [15:0] mem_addr;
  logic mem_rd;
  logic mem_io;
  logic [7:0] mem_rdata;
  logic busy;
  int n_errors = 0;
  int comparisons = 0;
  logic [15:0] pc = 16'h0000;
  logic [31:0] q;
  logic [7:0] fl, ef, tv;
  logic [15:0] d, x, y, src_addr;
  logic [6:0] k;
  logic t;
  int o;
  logic [7:0] fv [3] = '{8'h55, 8'hAA, 8'h00};
  logic [7:0] ro [7] = '{OFS_PC, OFS_FLAGS, OFS_PTR, OFS_STATUS, OFS_STACK, OFS_GPR_BASE, 8'h40};
  cpu_branch_skip_load_unit dut_u (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_io(mem_io), .mem_rdata(mem_rdata), .busy(busy));
  data_space_model mem_u (.clk(clk), .reset(reset), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_io(mem_io), .mem_rdata(mem_rdata));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic summarize();
    if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
    output logic [31:0] rq);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= dat;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      n_errors++;
      summarize();
    end
    rq = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] unused;
    wb(1'b1, adr, dat, unused);
  endtask
  task automatic rd(input logic [7:0] adr, output logic [31:0] rq);
    wb(1'b0, adr, 32'h0000_0000, rq);
  endtask
  // runs one instruction, pk writes the flags while it is busy
  task automatic ex(input logic [31:0] ins, input logic [15:0] npc, input logic [3:0] len,
    input logic pk);
    logic [31:0] s;
    int n;
    wr(OFS_INSTR, ins);
    if (pk) wr(OFS_FLAGS, 32'h0000_00FF);
    n = 0;
    do begin
      rd(OFS_STATUS, s);
      n++;
    end while (s[0] !== 1'b0 && n < 10);
    if (s[0] !== 1'b0) begin
      n_errors++;
      summarize();
    end
    `CHK("length", len, s[11:8])
    rd(OFS_PC, s);
    `CHK("pc", npc, s[15:0])
    pc = npc;
  endtask
  function automatic logic [31:0] mk(input int op, input int rdn, input int rrn, input int bt,
    input int im, input int lg);
    mk = {5'h00, lg[0], im[7:0], bt[2:0], rrn[4:0], rdn[4:0], op[4:0]};
  endfunction
  function automatic logic [7:0] cmpf(input logic [7:0] a, input logic [7:0] b,
    input logic [7:0] f, input logic c, input logic zk);
    logic [7:0] r;
    r = a - b - {7'h00, c};
    cmpf = f & 8'hC0;
    cmpf[FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    cmpf[FLAG_Z] = (r == 8'h00) & (f[FLAG_Z] | ~zk);
    cmpf[FLAG_N] = r[7];
    cmpf[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    cmpf[FLAG_S] = cmpf[FLAG_N] ^ cmpf[FLAG_V];
    cmpf[FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
  endfunction
  function automatic logic tk(input int op, input logic [7:0] f, input int b);
    int fi [4] = '{FLAG_H, FLAG_T, FLAG_V, FLAG_I};
    logic inv;
    inv = (op % 2 == 1);
    if (op <= op_branch_flag_clear) return f[b] ^ inv;
    if (op <= op_branch_zero_clear) return f[FLAG_Z] ^ inv;
    if (op <= op_branch_same_higher) return !f[FLAG_C];
    if (op <= op_branch_signed_lt) return f[FLAG_N] ^ f[FLAG_V] ^ !inv;
    return f[fi[(op - 16) / 2]] ^ inv;
  endfunction
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      rd(ro[i], q);
      `CHK("reset value", (ro[i] == OFS_STACK) ? {16'h0000, SP_RST} : 32'h0000_0000, q)
    end
    wr(OFS_GPR_BASE + 8'h04, 32'h0000_0033);
    wr(OFS_GPR_BASE + 8'h08, 32'h0000_0033);
    wr(OFS_GPR_BASE + 8'h0C, 32'h0000_0044);
    wr(OFS_ADDR, 32'h0000_0005);
    wr(OFS_FLAGS, 32'h0000_00C3);
    fl = 8'hC3;
    for (int i = 0; i < 3; i++) begin
      ef = cmpf(8'h33, (i == 0) ? 8'h44 : ((i == 1) ? 8'h33 : 8'h30), fl, (i == 1) & fl[0], i == 1);
      ex(mk(i, 1, (i == 0) ? 3 : 2, 0, 8'h30, 0), pc + 16'h0001, LEN_REG, 1'b0);
      rd(OFS_FLAGS, q);
      `CHK("flags", ef, q[7:0])
      rd(OFS_GPR_BASE + 8'h04, q);
      `CHK("r1", 8'h33, q[7:0])
      fl = ef;
    end
    for (int i = 0; i < 3; i++) begin
      d = (i == 2) ? 16'h0001 : 16'(2 + i);
      ex(mk(op_compare_skip_equal, 1, (i == 2) ? 3 : 2, 0, 0, i), pc + d, d[3:0], 1'b0);
    end
    for (int j = 0; j < 8; j++) begin
      o = 4 + j % 4;
      tv = (o >= 6) ? 8'h39 : ((j < 4) ? 8'h33 : 8'h44);
      d = ((o % 2 == 1) ? tv[j] : !tv[j]) ? 16'(2 + j / 4) : 16'h0001;
      ex(mk(o, (j < 4) ? 1 : 3, 0, j, 0, j / 4), pc + d, d[3:0] + 4'(o / 6), 1'b0);
    end
    for (int f = 0; f < 3; f++) begin
      wr(OFS_FLAGS, {24'h000000, fv[f]});
      for (int b = op_branch_flag_set; b <= op_branch_irq_disabled; b++) begin
        k = (b % 2 == 1) ? 7'h7D : 7'h05;
        t = tk(b, fv[f], b % 8);
        d = t ? {{9{k[6]}}, k} + 16'h0001 : 16'h0001;
        ex(mk(b, 0, 0, b % 8, k, 0), pc + d, t ? 4'h2 : 4'h1, 1'b0);
        rd(OFS_FLAGS, q);
        `CHK("flags kept", fv[f], q[7:0])
      end
    end
    wr(OFS_PTR, 32'h0230_0120);
    x = 16'h0120;
    y = 16'h0230;
    wr(OFS_ADDR, 32'h0000_1234);
    wr(OFS_FLAGS, 32'h0000_00A5);
    for (int l = op_load_x; l <= op_load_direct; l++) begin
      src_addr = (l >= op_load_y) ? y : x;
      if (l == op_load_x_dec) x = x - 16'h0001;
      if (l == op_load_x_dec) src_addr = x;
      if (l == op_load_direct) src_addr = 16'h1234;
      if (l == op_load_x_inc) x = x + 16'h0001;
      if (l == op_load_y_inc) y = y + 16'h0001;
      d = (l == op_load_direct) ? 16'h0002 : 16'h0001;
      ex(mk(l, l - 20, 0, 0, 0, 0), pc + d, LEN_MEM, 1'b0);
      rd(OFS_GPR_BASE + 8'(4 * (l - 20)), q);
      `CHK("loaded", src_addr[7:0] ^ 8'h5A, q[7:0])
      rd(OFS_PTR, q);
      `CHK("pointers", {y, x}, q)
      rd(OFS_FLAGS, q);
      `CHK("flags kept", 8'hA5, q[7:0])
    end
    wr(OFS_FLAGS, 32'h0000_0000);
    ex(mk(op_subroutine_return, 0, 0, 0, 0, 0), 16'h5A5B, LEN_POP, 1'b1);
    rd(OFS_FLAGS, q);
    `CHK("flags busy write", 8'h00, q[7:0])
    ex(mk(op_interrupt_return, 0, 0, 0, 0, 0), 16'h5859, LEN_POP, 1'b0);
    rd(OFS_FLAGS, q);
    `CHK("irq flag", 8'h80, q[7:0])
    rd(OFS_STACK, q);
    `CHK("stack", 16'h0103, q[15:0])
    summarize();
  end
endmodule
